// ### core/rfi_core.sv
// fetch, cache fill, decode and issue front end with scoreboard and alu bypass
// assumes a fill port returning four in-order words per burst and a
// separate load/store port returning load data tagged with the target register
`default_nettype none
module rfi_core (
   input  wire logic        i_mclk,       // core clock
   input  wire logic        i_rstn,       // synchronous reset, active low
   output logic             o_fill_req,   // burst fill request
   output logic [31:0]      o_fill_addr,  // line address of fill
   input  wire logic        i_fill_ack,   // fill request taken
   input  wire logic        i_fill_valid, // fill word strobe
   input  wire logic [31:0] i_fill_data,  // fill word
   output logic             o_mem_req,    // data access request
   output logic             o_mem_we,     // store when high
   output logic [31:0]      o_mem_addr,   // data byte address
   output logic [31:0]      o_mem_wdata,  // store data
   output logic [4:0]       o_mem_tag,    // load target register
   input  wire logic        i_mem_ack,    // data request taken
   input  wire logic        i_ld_valid,   // load data strobe
   input  wire logic [4:0]  i_ld_tag,     // load target register
   input  wire logic [31:0] i_ld_data,    // load data
   output logic             o_wb_valid,   // alu result strobe
   output logic [4:0]       o_wb_reg,     // alu result register
   output logic [31:0]      o_wb_data,    // alu result
   output logic [31:0]      o_sb_busy     // scoreboard bits
);
   localparam int NW = rfi_pkg::NLINES * rfi_pkg::LINE_WORDS;
   typedef enum {F_IDLE, F_REQ, F_DATA} rfi_fill_t;

   logic [31:0] pc_reg, dec_pc_reg, dec_reg;
   logic        dec_vld_reg;
   logic [31:0] ic_data [NW];
   logic [rfi_pkg::TAG_W-1:0] ic_tag [rfi_pkg::NLINES];
   logic [rfi_pkg::NLINES-1:0] ic_vld_reg;
   rfi_fill_t   fill_st;
   logic [31:0] fill_addr_reg;
   logic [1:0]  fill_cnt_reg;
   logic [31:0] rf [rfi_pkg::NREG];
   logic [31:0] sb_reg;
   logic [1:0]  ld_cnt_reg;
   logic        cc_reg, cc_pend_reg, cc_stage_reg;
   logic        wb_vld_reg;
   logic [4:0]  wb_reg_reg;
   logic [31:0] wb_data_reg;
   logic        mem_req_reg, mem_we_reg;
   logic [31:0] mem_addr_reg, mem_wdata_reg;
   logic [4:0]  mem_tag_reg;

   // fetch side lookup
   logic [4:0]  pc_idx, nx_idx;
   logic [1:0]  pc_w;
   logic [31:0] nx_line;
   logic        hit, nx_hit, fwd, fill_last;
   assign pc_idx = pc_reg[rfi_pkg::TAG_LO-1:rfi_pkg::LOFF_W];
   assign pc_w   = pc_reg[rfi_pkg::LOFF_W-1:rfi_pkg::WOFF_W];
   assign hit    = ic_vld_reg[pc_idx] && ic_tag[pc_idx] == pc_reg[31:rfi_pkg::TAG_LO];
   assign nx_line = {pc_reg[31:rfi_pkg::LOFF_W] + 28'h1, 4'h0};
   assign nx_idx = nx_line[rfi_pkg::TAG_LO-1:rfi_pkg::LOFF_W];
   assign nx_hit = ic_vld_reg[nx_idx] && ic_tag[nx_idx] == nx_line[31:rfi_pkg::TAG_LO];
   assign fill_last = fill_st == F_DATA && i_fill_valid && fill_cnt_reg == 2'h3;
   assign fwd = fill_st == F_DATA && i_fill_valid && fill_cnt_reg == pc_w &&
                fill_addr_reg[31:rfi_pkg::LOFF_W] == pc_reg[31:rfi_pkg::LOFF_W];

   // decode
   rfi_pkg::rfi_fmt_t fmt;
   logic [4:0]  dst, s1, s2;
   logic [31:0] a, b, alu;
   logic        is_mem, is_st, is_ld, rd1, rd2, rdd, wrd, hz, stall, issue;
   logic        redirect;
   logic [31:0] target;
   assign fmt    = rfi_pkg::rfi_fmt(dec_reg);
   assign dst    = dec_reg[rfi_pkg::DST_LO +: rfi_pkg::RIDX_W];
   assign s1     = dec_reg[rfi_pkg::SRC1_LO +: rfi_pkg::RIDX_W];
   assign s2     = dec_reg[rfi_pkg::SRC2_LO +: rfi_pkg::RIDX_W];
   assign is_mem = fmt == rfi_pkg::FMT_MEMS || fmt == rfi_pkg::FMT_MEML;
   assign is_st  = is_mem && dec_reg[rfi_pkg::OPC_LO];
   assign is_ld  = is_mem && !dec_reg[rfi_pkg::OPC_LO];
   assign rd1    = fmt != rfi_pkg::FMT_CTRL;
   assign rd2    = fmt == rfi_pkg::FMT_REG || fmt == rfi_pkg::FMT_COBR ||
                   fmt == rfi_pkg::FMT_MEML;
   assign rdd    = is_st;
   assign wrd    = fmt == rfi_pkg::FMT_REG || is_ld;
   // any instruction touching a pending register waits
   assign hz = (rd1 && sb_reg[s1]) || (rd2 && sb_reg[s2]) ||
               (rdd && sb_reg[dst]) || (wrd && sb_reg[dst]);
   always_comb begin
      stall = hz;
      if ((fmt == rfi_pkg::FMT_CTRL && dec_reg[rfi_pkg::OPC_LO]) ||
          fmt == rfi_pkg::FMT_COBR) stall = stall || cc_pend_reg;
      if (is_ld && ld_cnt_reg == 2'(rfi_pkg::MAX_LOADS)) stall = 1'b1;
      if (is_mem && mem_req_reg && !i_mem_ack) stall = 1'b1;
   end
   assign issue = dec_vld_reg && !stall;

   // operands with bypass from the alu result
   assign a = (wb_vld_reg && wb_reg_reg == s1) ? wb_data_reg : rf[s1];
   assign b = (wb_vld_reg && wb_reg_reg == s2) ? wb_data_reg : rf[s2];
   always_comb begin
      unique case (dec_reg[rfi_pkg::OPC_LO +: 3])
         3'h0: alu = a + b;
         3'h1: alu = a - b;
         3'h2: alu = a & b;
         3'h3: alu = a | b;
         3'h4: alu = a ^ b;
         3'h5: alu = a << b[4:0];
         3'h6: alu = a >> b[4:0];
         3'h7: alu = b;
      endcase
   end
   assign target = dec_pc_reg + {{8{dec_reg[23]}}, dec_reg[23:2], 2'b00};
   assign redirect = issue && fmt == rfi_pkg::FMT_CTRL &&
                     (!dec_reg[rfi_pkg::OPC_LO] || cc_reg);

   // program counter and decode register
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         pc_reg      <= rfi_pkg::PC_RST;
         dec_vld_reg <= 1'b0;
         dec_reg     <= 32'h0;
         dec_pc_reg  <= 32'h0;
      end else if (redirect) begin
         pc_reg      <= target;
         dec_vld_reg <= 1'b0;
      end else if (!dec_vld_reg || issue) begin
         dec_vld_reg <= hit || fwd;
         dec_pc_reg  <= pc_reg;
         if (hit) dec_reg <= ic_data[{pc_idx, pc_w}];
         else if (fwd) dec_reg <= i_fill_data;
         if (hit || fwd) pc_reg <= pc_reg + 32'h4;
      end
   end

   // burst fill and prefetch of the next line
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         fill_st       <= F_IDLE;
         fill_addr_reg <= 32'h0;
         fill_cnt_reg  <= 2'h0;
         ic_vld_reg    <= '0;
      end else begin
         unique case (fill_st)
            F_IDLE: begin
               if (!hit || !nx_hit) begin
                  fill_st <= F_REQ;
                  fill_addr_reg <= !hit ? {pc_reg[31:4], 4'h0} : nx_line;
                  ic_vld_reg[!hit ? pc_idx : nx_idx] <= 1'b0;
                  ic_tag[!hit ? pc_idx : nx_idx] <= !hit ? pc_reg[31:9] : nx_line[31:9];
               end
            end
            F_REQ: begin
               if (i_fill_ack) begin
                  fill_st      <= F_DATA;
                  fill_cnt_reg <= 2'h0;
               end
            end
            F_DATA: begin
               if (i_fill_valid) fill_cnt_reg <= fill_cnt_reg + 2'h1;
               if (fill_last) begin
                  fill_st <= F_IDLE;
                  ic_vld_reg[fill_addr_reg[8:4]] <= 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (fill_st == F_DATA && i_fill_valid)
         ic_data[{fill_addr_reg[8:4], fill_cnt_reg}] <= i_fill_data;
   end

   // register file: alu port and load port never hit the same register
   always_ff @(posedge i_mclk) begin
      if (wb_vld_reg) rf[wb_reg_reg] <= wb_data_reg;
      if (i_ld_valid) rf[i_ld_tag] <= i_ld_data;
   end

   // scoreboard and load count
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         sb_reg     <= 32'h0;
         ld_cnt_reg <= 2'h0;
      end else begin
         for (int r = 0; r < rfi_pkg::NREG; r++) begin
            if (issue && is_ld && dst == 5'(r)) sb_reg[r] <= 1'b1;
            else if (i_ld_valid && i_ld_tag == 5'(r)) sb_reg[r] <= 1'b0;
         end
         ld_cnt_reg <= ld_cnt_reg + 2'(issue && is_ld) - 2'(i_ld_valid);
      end
   end

   // condition code: one cycle pending after a compare
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         cc_reg       <= 1'b0;
         cc_pend_reg  <= 1'b0;
         cc_stage_reg <= 1'b0;
      end else begin
         cc_pend_reg <= issue && fmt == rfi_pkg::FMT_COBR;
         if (issue && fmt == rfi_pkg::FMT_COBR)
            cc_stage_reg <= dec_reg[rfi_pkg::OPC_LO] ? (a < b) : (a == b);
         if (cc_pend_reg) cc_reg <= cc_stage_reg;
      end
   end

   // alu result stage
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         wb_vld_reg  <= 1'b0;
         wb_reg_reg  <= 5'h0;
         wb_data_reg <= 32'h0;
      end else begin
         wb_vld_reg <= issue && fmt == rfi_pkg::FMT_REG;
         if (issue && fmt == rfi_pkg::FMT_REG) begin
            wb_reg_reg  <= dst;
            wb_data_reg <= alu;
         end
      end
   end

   // data port, loads and stores only
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         mem_req_reg   <= 1'b0;
         mem_we_reg    <= 1'b0;
         mem_addr_reg  <= 32'h0;
         mem_wdata_reg <= 32'h0;
         mem_tag_reg   <= 5'h0;
      end else if (issue && is_mem) begin
         mem_req_reg   <= 1'b1;
         mem_we_reg    <= is_st;
         mem_tag_reg   <= dst;
         mem_wdata_reg <= (wb_vld_reg && wb_reg_reg == dst) ? wb_data_reg : rf[dst];
         mem_addr_reg  <= fmt == rfi_pkg::FMT_MEMS ? a + {20'h0, dec_reg[11:0]} :
                          a + (b << dec_reg[rfi_pkg::SCALE_LO +: 2]);
      end else if (i_mem_ack) begin
         mem_req_reg <= 1'b0;
      end
   end

   assign o_fill_req  = fill_st == F_REQ;
   assign o_fill_addr = fill_addr_reg;
   assign o_mem_req   = mem_req_reg;
   assign o_mem_we    = mem_we_reg;
   assign o_mem_addr  = mem_addr_reg;
   assign o_mem_wdata = mem_wdata_reg;
   assign o_mem_tag   = mem_tag_reg;
   assign o_wb_valid  = wb_vld_reg;
   assign o_wb_reg    = wb_reg_reg;
   assign o_wb_data   = wb_data_reg;
   assign o_sb_busy   = sb_reg;

   // independent count of fill words for the burst check
   logic [2:0] beat_n_reg;
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || fill_st == F_REQ) beat_n_reg <= 3'h0;
      else if (fill_st == F_DATA && i_fill_valid) beat_n_reg <= beat_n_reg + 3'h1;
   end

   a_pc_aligned: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      pc_reg[1:0] == 2'b00) else $error("pc not word aligned");
   a_fill_line: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_fill_req |-> o_fill_addr[3:0] == 4'h0) else $error("fill not line aligned");
   a_burst_four: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (fill_st == F_DATA && i_fill_valid) |=>
      (fill_st == F_IDLE) == ($past(beat_n_reg) == 3'h3))
      else $error("burst not four words");
   a_miss_fwd: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (fwd && !dec_vld_reg && !redirect) |=> dec_vld_reg && dec_reg == $past(i_fill_data))
      else $error("missed word not forwarded");
   a_alu_onecyc: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (issue && fmt == rfi_pkg::FMT_REG) |=> wb_vld_reg && wb_data_reg == $past(alu))
      else $error("alu result late");
   a_bypass_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      wb_vld_reg |=> rf[$past(wb_reg_reg)] == $past(wb_data_reg))
      else $error("result not written");
   a_load_limit: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $countones(sb_reg) == int'(ld_cnt_reg) && ld_cnt_reg <= 2'(rfi_pkg::MAX_LOADS) &&
      !(issue && is_ld && ld_cnt_reg == 2'(rfi_pkg::MAX_LOADS)))
      else $error("too many loads");
   a_sb_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      issue |-> !(rd1 && sb_reg[s1]) && !(rd2 && sb_reg[s2])) else $error("read of pending reg");
   a_cond_wait: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (issue && fmt == rfi_pkg::FMT_CTRL && dec_reg[rfi_pkg::OPC_LO]) |-> !cc_pend_reg)
      else $error("branch on pending cc");
   a_mem_only_ls: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $rose(mem_req_reg) |-> $past(is_mem && issue)) else $error("non memory op on data port");
   a_reset_clear: assert property (@(posedge i_mclk) disable iff (1'b0)
      !i_rstn |=> sb_reg == 32'h0 && ic_vld_reg == '0 && fill_st == F_IDLE)
      else $error("reset did not clear");
endmodule // rfi_core
`default_nettype wire

// ### core/rfi_pkg.sv
// constants, field layout and format decode for the fetch/issue front end
// assumes a single core clock and byte-addressed 32-bit memory
`default_nettype none
package rfi_pkg;
   localparam int XLEN        = 32;
   localparam int NREG        = 32;
   localparam int RIDX_W      = 5;
   localparam int CACHE_BYTES = 512;
   localparam int LINE_BYTES  = 16;
   localparam int LINE_WORDS  = LINE_BYTES / 4;
   localparam int NLINES      = CACHE_BYTES / LINE_BYTES;
   localparam int WOFF_W      = 2;
   localparam int LOFF_W      = 4;
   localparam int IDX_W       = 5;
   localparam int TAG_LO      = LOFF_W + IDX_W;
   localparam int TAG_W       = XLEN - TAG_LO;
   localparam int MAX_LOADS   = 3;
   localparam int OPC_LO      = 24;
   localparam int DST_LO      = 19;
   localparam int SRC1_LO     = 14;
   localparam int SRC2_LO     = 0;
   localparam int MLONG_BIT   = 12;
   localparam int SCALE_LO    = 7;
   localparam int OFS_W       = 12;
   localparam logic [31:0] PC_RST = 32'h0000_0000;
   localparam logic [7:0]  OPC_COBR = 8'h20;
   localparam logic [7:0]  OPC_REG  = 8'h40;
   localparam logic [7:0]  OPC_MEM  = 8'h80;

   typedef enum logic [2:0] {FMT_CTRL, FMT_COBR, FMT_REG, FMT_MEMS, FMT_MEML} rfi_fmt_t;

   // each instruction word falls into exactly one format
   function automatic rfi_fmt_t rfi_fmt(input logic [31:0] w);
      rfi_fmt_t f;
      f = FMT_CTRL;
      if (w[31:24] >= OPC_MEM) f = w[MLONG_BIT] ? FMT_MEML : FMT_MEMS;
      else if (w[31:24] >= OPC_REG) f = FMT_REG;
      else if (w[31:24] >= OPC_COBR) f = FMT_COBR;
      return f;
   endfunction
endpackage
`default_nettype wire

// ### verification/rfi_mem_model.sv
// memory model answering cache fills and data accesses of the front end
// assumes requests stand until acknowledged; i_lat slows fill acks and load data
`default_nettype none
module rfi_mem_model (
   input  wire logic        i_mclk,       // core clock
   input  wire logic        i_rstn,       // sync reset, active low
   input  wire logic [7:0]  i_lat,        // load data delay in cycles; fill ack waits i_lat/8 cycles
   input  wire logic [31:0] i_rom [0:31], // program words
   input  wire logic        i_fill_req,   // fill request
   input  wire logic [31:0] i_fill_addr,  // fill line address
   output logic             o_fill_ack,   // fill taken
   output logic             o_fill_valid, // fill word strobe
   output logic [31:0]      o_fill_data,  // fill word
   input  wire logic        i_mem_req,    // data request
   input  wire logic        i_mem_we,     // store when high
   input  wire logic [4:0]  i_mem_tag,    // load target
   output logic             o_mem_ack,    // data taken
   output logic             o_ld_valid,   // load data strobe
   output logic [4:0]       o_ld_tag,     // load target
   output logic [31:0]      o_ld_data     // load data
);
   timeunit 1ns;
   timeprecision 1ps;
   int         wait_n, beat, cyc;
   int         due[$];
   logic [4:0] tags[$];
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      o_fill_ack <= 1'b0;
      o_fill_valid <= 1'b0;
      o_fill_data <= ~o_fill_data;
      o_ld_valid <= 1'b0;
      o_ld_data <= ~o_ld_data;
      o_mem_ack <= i_mem_req && !o_mem_ack;
      if (!i_rstn) begin
         // pending fill and loads are abandoned
         wait_n <= 0;
         beat <= 0;
         o_mem_ack <= 1'b0;
         o_fill_data <= 32'h5a5a_5a5a;
         o_ld_data <= 32'ha5a5_a5a5;
         due.delete();
         tags.delete();
      end else begin
         if (beat == 0 && i_fill_req && !o_fill_ack) begin
            if (wait_n < int'(i_lat >> 3)) begin
               wait_n <= wait_n + 1;
            end else begin
               o_fill_ack <= 1'b1;
               wait_n <= 0;
               beat <= 1;
            end
         end else if (beat != 0) begin
            // four words in order, one line per burst
            o_fill_valid <= 1'b1;
            o_fill_data <= i_rom[{i_fill_addr[6:4], 2'(beat - 1)}];
            beat <= (beat == 4) ? 0 : beat + 1;
         end
         if (i_mem_req && o_mem_ack && !i_mem_we) begin
            tags.push_back(i_mem_tag);
            due.push_back(cyc + int'(i_lat));
         end
         if (due.size() > 0 && due[0] <= cyc) begin
            o_ld_valid <= 1'b1;
            o_ld_tag <= tags[0];
            o_ld_data <= 32'h100 + 32'(tags[0]);
            void'(due.pop_front());
            void'(tags.pop_front());
         end
      end
   end
endmodule // rfi_mem_model
`default_nettype wire

// ### verification/tb_risc_core_fetch_issue.sv
// self-checking bench for the fetch/issue front end
// assumes rfi_mem_model on the fill and data ports; loads return 0x100+tag
`default_nettype none
module tb_risc_core_fetch_issue;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_mclk, i_rstn, o_fill_req, i_fill_ack, i_fill_valid, o_mem_req, o_mem_we;
   logic        i_mem_ack, i_ld_valid, o_wb_valid, r4_busy;
   logic [31:0] o_fill_addr, i_fill_data, o_mem_addr, o_mem_wdata, i_ld_data, o_wb_data;
   logic [31:0] o_sb_busy;
   logic [4:0]  o_mem_tag, i_ld_tag, o_wb_reg;
   logic [7:0]  lat;
   logic [31:0] rom [0:31];
   logic [36:0] exp_wb [0:9];
   logic [64:0] memq[$];
   logic [36:0] wbq[$];
   logic [31:0] fillq[$];
   int          fail_count, n_checks, max_sb;
   rfi_core DUT (.i_mclk, .i_rstn, .o_fill_req, .o_fill_addr, .i_fill_ack, .i_fill_valid,
      .i_fill_data, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_mem_tag, .i_mem_ack,
      .i_ld_valid, .i_ld_tag, .i_ld_data, .o_wb_valid, .o_wb_reg, .o_wb_data, .o_sb_busy);
   rfi_mem_model mem (.i_mclk, .i_rstn, .i_lat(lat), .i_rom(rom), .i_fill_req(o_fill_req),
      .i_fill_addr(o_fill_addr), .o_fill_ack(i_fill_ack), .o_fill_valid(i_fill_valid),
      .o_fill_data(i_fill_data), .i_mem_req(o_mem_req), .i_mem_we(o_mem_we),
      .i_mem_tag(o_mem_tag), .o_mem_ack(i_mem_ack), .o_ld_valid(i_ld_valid),
      .o_ld_tag(i_ld_tag), .o_ld_data(i_ld_data));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) if (i_rstn) begin
      if (o_wb_valid) wbq.push_back({o_wb_reg, o_wb_data});
      if (o_wb_valid && o_wb_reg === 5'd5) r4_busy = o_sb_busy[4];
      if (o_mem_req && i_mem_ack) memq.push_back({o_mem_we, o_mem_addr, o_mem_wdata});
      if (o_fill_req && i_fill_ack) fillq.push_back(o_fill_addr);
      if ($countones(o_sb_busy) > max_sb) max_sb = $countones(o_sb_busy);
   end
   function automatic logic [31:0] rop(input logic [2:0] op, input logic [4:0] d, a, b);
      return {5'b01000, op, d, a, 9'h000, b};
   endfunction
   function automatic logic [31:0] ld(input logic [4:0] d, input logic [13:0] mode);
      return {8'h80, d, 5'd0, mode};
   endfunction
   task automatic chk(input string what, input logic [64:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic do_reset(input int n);
      @(posedge i_mclk);
      #2 i_rstn = 1'b0;
      repeat (n) @(posedge i_mclk);
      #2 i_rstn = 1'b1;
      wbq.delete();
      memq.delete();
      fillq.delete();
      max_sb = 0;
      r4_busy = 1'b0;
   endtask
   task automatic run_check();
      int k;
      for (k = 0; k < 4000 && (wbq.size() < 10 || memq.size() < 5); k++) @(posedge i_mclk);
      if (k == 4000) begin
         fail_count++;
         $display("unexpected timeout waiting for program end");
         stop_test();
      end
      for (k = 0; k < 10; k++) chk("alu result", exp_wb[k], wbq[k]);
      for (k = 0; k < 4; k++) chk("load kind", 0, memq[k][64]);
      chk("store", {1'b1, 32'h105, 32'h205}, memq[4]);
      foreach (fillq[k]) chk("fill align", 0, fillq[k][3:0]);
      chk("first fill", 0, fillq[0]);
      chk("prefetch fill", 32'h10, fillq[1]);
      chk("loads pending", 1, max_sb <= 3);
   endtask
   task automatic t_slow();
      #2 lat = 8'd40;
      do_reset(3);
      run_check();
      chk("three loads pending", 3, max_sb);
      chk("issue past load", 1, r4_busy);
   endtask
   task automatic t_fast();
      #2 lat = 8'd0;
      do_reset(3);
      run_check();
   endtask
   task automatic t_mid_reset();
      int k;
      #2 lat = 8'd40;
      do_reset(3);
      for (k = 0; k < 500 && o_sb_busy === 32'h0; k++) @(posedge i_mclk);
      if (k == 500) begin
         fail_count++;
         $display("unexpected timeout waiting for a pending load");
         stop_test();
      end
      repeat (2) @(posedge i_mclk);
      do_reset(1);
      chk("busy in reset", 0, o_sb_busy);
      chk("fill in reset", 0, o_fill_req);
      @(posedge i_mclk);
      #2 chk("refill", {1'b1, 32'h0}, {o_fill_req, o_fill_addr});
      run_check();
   endtask
   initial begin
      i_rstn = 1'b0;
      lat = 8'd0;
      foreach (rom[k]) rom[k] = 32'h0;
      rom[0] = ld(5'd1, 14'h0000);
      rom[1] = ld(5'd2, 14'h0000);
      rom[2] = ld(5'd3, 14'h0000);
      rom[3] = ld(5'd4, 14'h1000);
      rom[4] = rop(3'd0, 5'd5, 5'd1, 5'd2);
      rom[5] = rop(3'd1, 5'd6, 5'd5, 5'd3);
      rom[6] = rop(3'd2, 5'd7, 5'd6, 5'd1);
      rom[7] = rop(3'd3, 5'd8, 5'd7, 5'd2);
      rom[8] = rop(3'd4, 5'd9, 5'd8, 5'd3);
      rom[9] = rop(3'd5, 5'd10, 5'd1, 5'd9);
      rom[10] = rop(3'd6, 5'd11, 5'd10, 5'd9);
      rom[11] = {8'h20, 5'd0, 5'd1, 9'h000, 5'd1};
      rom[12] = rop(3'd7, 5'd12, 5'd11, 5'd11);
      rom[13] = rop(3'd0, 5'd13, 5'd4, 5'd12);
      rom[14] = {8'h81, 5'd13, 5'd1, 14'h0004};
      // conditional branch on the equal compare skips the next word
      rom[15] = 32'h0100_0008;
      rom[16] = rop(3'd7, 5'd14, 5'd1, 5'd1);
      rom[17] = rop(3'd0, 5'd15, 5'd5, 5'd6);
      exp_wb = '{{5'd5, 32'h203}, {5'd6, 32'h100}, {5'd7, 32'h100}, {5'd8, 32'h102},
                 {5'd9, 32'h001}, {5'd10, 32'h202}, {5'd11, 32'h101}, {5'd12, 32'h101},
                 {5'd13, 32'h205}, {5'd15, 32'h303}};
      t_slow();
      t_fast();
      t_mid_reset();
      stop_test();
   end
endmodule // tb_risc_core_fetch_issue
`default_nettype wire
